// >>> hdl/agu_pkg.sv
// package: register map, field layout, modes and types of the address units
package agu_pkg;
  localparam logic [31:0] OFS_CTRL      = 32'h0000_0000;
  localparam logic [31:0] OFS_X_START   = 32'h0000_0004;
  localparam logic [31:0] OFS_X_END     = 32'h0000_0008;
  localparam logic [31:0] OFS_Y_START   = 32'h0000_000C;
  localparam logic [31:0] OFS_Y_END     = 32'h0000_0010;
  localparam logic [31:0] OFS_X_PTR_A   = 32'h0000_0014;
  localparam logic [31:0] OFS_X_PTR_B   = 32'h0000_0018;
  localparam logic [31:0] OFS_Y_PTR_A   = 32'h0000_001C;
  localparam logic [31:0] OFS_Y_PTR_B   = 32'h0000_0020;
  localparam logic [31:0] OFS_STATUS    = 32'h0000_0024;
  localparam int          CTRL_X_EN_BIT = 15;
  localparam int          CTRL_Y_EN_BIT = 14;
  localparam int          XSEL_LO       = 0;
  localparam int          YSEL_LO       = 4;
  localparam logic [3:0]  SEL_NONE      = 4'hF;
  localparam logic [15:0] CTRL_MASK     = 16'hC0FF;
  localparam logic [15:0] RST_CTRL      = 16'h0000;
  localparam logic [15:0] RST_START     = 16'h0000;
  localparam logic [15:0] RST_END       = 16'h0001;
  localparam logic [15:0] NEAR_LIMIT    = 16'h2000;
  localparam logic [15:0] WORD_MASK     = 16'hFFFE;
  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_SLVERR   = 2'b10;

  typedef enum logic [2:0] {
    AM_INDIRECT = 3'd0,
    AM_POST     = 3'd1,
    AM_PRE      = 3'd2,
    AM_INDEXED  = 3'd3,
    AM_LITERAL  = 3'd4,
    AM_FILE     = 3'd5
  } addr_mode_t;

  typedef enum logic [1:0] {
    IC_FILE = 2'd0,
    IC_MCU  = 2'd1,
    IC_MOVE = 2'd2,
    IC_MAC  = 2'd3
  } instr_class_t;

  // one address request from the decoder
  typedef struct packed {
    logic         valid;
    instr_class_t iclass;
    addr_mode_t   mode;
    logic [3:0]   base_sel;
    logic [15:0]  base_val;
    logic [15:0]  offset_val;
    logic [15:0]  literal;
    logic [12:0]  file_addr;
    logic         is_move;
    logic         prog_space;
  } ea_req_t;

  typedef struct packed {
    logic        valid;
    logic        error;
    logic [15:0] ea;
    logic        wb_en;
    logic [3:0]  wb_sel;
    logic [15:0] wb_val;
  } ea_rsp_t;
endpackage

// >>> hdl/circ_wrap.sv
// combinational circular-buffer correction of one candidate address
`timescale 1ns/1ns
module circ_wrap
  import agu_pkg::*;
(
  input  wire logic [15:0] addr,
  input  wire logic [15:0] start_a,
  input  wire logic [15:0] end_a,
  input  wire logic        active,
  output logic      [15:0] wrapped
);
  logic [16:0] len;
  always_comb begin
    // length is end minus start plus one, at most 64 Kbytes
    len = {1'b0, end_a} - {1'b0, start_a} + 17'h0_0001;
    wrapped = addr;
    // beyond the boundary, not only equal to it
    if (active && addr > end_a) begin
      wrapped = 16'((17'(addr) - len));
    end else if (active && addr < start_a) begin
      wrapped = 16'((17'(addr) + len));
    end
  end
endmodule // circ_wrap

// >>> hdl/address_generator_units.sv
// top: X and Y effective-address units with an AXI4-Lite control slave
`timescale 1ns/1ns
// Summary of operation
// - separate X and Y units compute effective addresses independently.
// - Y unit only serves word reads of multiply-accumulate instructions.
// - linear and circular modes work for data and program space.
// - file instructions use 13-bit direct address in first 8192 bytes.
// - move instructions may reach the whole data space.
// - indirect and post-modify use pointer as address; post then steps.
// - pre-modify steps pointer by signed constant and uses new value.
// - indexed address is base pointer plus offset register.
// - literal-offset address is base pointer plus instruction literal.
// - three-operand first operand is a direct working register.
// - move source and destination share one 4-bit offset field.
// - prefetch pointers A,B go to X unit; Y pointers A,B to Y unit.
// - MAC indexed mode only for second X and second Y pointer.
// - MAC post-modify steps limited to 2, 4 or 6.
// - one circular buffer in X space, one in Y space.
// - power-of-two buffers check both lower and upper bounds.
// - each buffer has 16-bit start and end registers.
// - Y circular addresses are word aligned, low bit zero.
// - buffer length is end minus start plus one, at most 64 Kbytes.
// - X circular only when X select is not 15 and bit 15 set.
// - Y circular only when Y select is not 15 and bit 14 set.
// - boundary checks catch addresses beyond, not only equal.
// - wrapped value written back only for pre- or post-modify.
module address_generator_units
  import agu_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire ea_req_t     x_req,
  input  wire ea_req_t     y_req,
  output ea_rsp_t          x_rsp,
  output ea_rsp_t          y_rsp
);
  logic [15:0] circ_control_q;
  logic [15:0] x_circ_start_q, x_circ_end_q;
  logic [15:0] y_circ_start_q, y_circ_end_q;
  logic [15:0] x_prefetch_ptr_a_q, x_prefetch_ptr_b_q;
  logic [15:0] y_prefetch_ptr_a_q, y_prefetch_ptr_b_q;
  logic [1:0]  err_sticky_q;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } wr_state_t;
  wr_state_t   wr_state_q;
  logic        aw_got_q, w_got_q;
  logic [31:0] aw_addr_q, w_data_q;
  logic [3:0]  w_strb_q;

  // signed step rides in the literal; only magnitudes 2, 4, 6 pass
  function automatic logic mac_step_ok(input logic [15:0] s);
    logic [15:0] m;
    m = s[15] ? 16'(-s) : s;
    return (m == 16'h0002) || (m == 16'h0004) || (m == 16'h0006);
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  st);
    merge16 = old;
    if (st[0]) merge16[7:0]  = d[7:0];
    if (st[1]) merge16[15:8] = d[15:8];
  endfunction

  // circular enable per space
  logic x_circ_enable, y_circ_enable;
  logic [3:0] x_circ_pointer_select, y_circ_pointer_select;
  assign x_circ_pointer_select = circ_control_q[XSEL_LO +: 4];
  assign y_circ_pointer_select = circ_control_q[YSEL_LO +: 4];
  assign x_circ_enable = circ_control_q[CTRL_X_EN_BIT] &&
                         x_circ_pointer_select != SEL_NONE;
  assign y_circ_enable = circ_control_q[CTRL_Y_EN_BIT] &&
                         y_circ_pointer_select != SEL_NONE;

  // per-unit address computation, shared by a generate loop
  ea_req_t     req   [2];
  logic [15:0] c_st  [2];
  logic [15:0] c_en  [2];
  logic        c_on  [2];
  logic [15:0] cand  [2];
  logic [15:0] newp  [2];
  logic [15:0] w_ea  [2];
  logic [15:0] w_np  [2];
  logic        bad   [2];
  ea_rsp_t     rsp_d [2];
  ea_rsp_t     rsp_q [2];

  assign req[0]  = x_req;
  assign req[1]  = y_req;
  assign c_st[0] = x_circ_start_q;
  assign c_en[0] = x_circ_end_q;
  assign c_st[1] = y_circ_start_q;
  assign c_en[1] = y_circ_end_q;
  // one buffer in each space; X also covers program space
  // direct file addresses carry no pointer, so never wrap
  assign c_on[0] = x_circ_enable && x_req.mode != AM_FILE &&
                   x_req.base_sel == x_circ_pointer_select;
  assign c_on[1] = y_circ_enable && y_req.mode != AM_FILE &&
                   y_req.base_sel == y_circ_pointer_select;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_unit
      always_comb begin
        cand[g] = req[g].base_val;
        newp[g] = req[g].base_val;
        bad[g]  = 1'b0;
        case (req[g].mode)
          AM_INDIRECT: cand[g] = req[g].base_val;
          AM_POST: begin
            cand[g] = req[g].base_val;
            newp[g] = req[g].base_val + req[g].literal;
          end
          AM_PRE: begin
            newp[g] = req[g].base_val + req[g].literal;
            cand[g] = newp[g];
          end
          // one offset field per request, shared by move ends
          AM_INDEXED: cand[g] = req[g].base_val + req[g].offset_val;
          AM_LITERAL: cand[g] = req[g].base_val + req[g].literal;
          AM_FILE: begin
            cand[g] = {3'b000, req[g].file_addr};
            // move may reach all of data space
            if (req[g].is_move) cand[g] = req[g].literal;
          end
          default: bad[g] = 1'b1;
        endcase
        // operand 1 of three-operand ops is register direct
        if (req[g].iclass == IC_MCU &&
            (req[g].mode == AM_INDEXED || req[g].mode == AM_FILE))
          bad[g] = 1'b1;
        if (req[g].iclass == IC_MAC) begin
          // X gets prefetch A/B (8,9), Y gets (10,11)
          if (g == 0 && req[g].base_sel != 4'd8 && req[g].base_sel != 4'd9)
            bad[g] = 1'b1;
          if (g == 1 && req[g].base_sel != 4'd10 && req[g].base_sel != 4'd11)
            bad[g] = 1'b1;
          // indexed only through second pointer
          if (req[g].mode == AM_INDEXED && !req[g].base_sel[0])
            bad[g] = 1'b1;
          // MAC modes and steps
          if (req[g].mode == AM_POST && !mac_step_ok(req[g].literal))
            bad[g] = 1'b1;
          if (req[g].mode == AM_PRE || req[g].mode == AM_LITERAL ||
              req[g].mode == AM_FILE)
            bad[g] = 1'b1;
        end
        // Y serves only MAC word reads
        if (g == 1 && req[g].iclass != IC_MAC)
          bad[g] = 1'b1;
      end

      circ_wrap u_wrap_ea (
        .addr    (cand[g]),
        .start_a (c_st[g]),
        .end_a   (c_en[g]),
        .active  (c_on[g]),
        .wrapped (w_ea[g])
      );
      circ_wrap u_wrap_ptr (
        .addr    (newp[g]),
        .start_a (c_st[g]),
        .end_a   (c_en[g]),
        .active  (c_on[g]),
        .wrapped (w_np[g])
      );

      always_comb begin
        rsp_d[g].valid  = req[g].valid;
        rsp_d[g].error  = req[g].valid && bad[g];
        rsp_d[g].ea     = w_ea[g];
        // Y words: low bit forced clear
        if (g == 1) rsp_d[g].ea = w_ea[g] & WORD_MASK;
        // pointer written back only for pre/post modify
        rsp_d[g].wb_en  = req[g].valid && !bad[g] &&
                          (req[g].mode == AM_PRE || req[g].mode == AM_POST);
        rsp_d[g].wb_sel = req[g].base_sel;
        rsp_d[g].wb_val = w_np[g];
      end

      always_ff @(posedge aclk) begin
        if (!aresetn) rsp_q[g] <= '0;
        else          rsp_q[g] <= rsp_d[g];
      end
    end
  endgenerate

  assign x_rsp = rsp_q[0];
  assign y_rsp = rsp_q[1];

  // shadow prefetch pointers follow X writebacks to selects 8, 9 and Y writebacks to selects 10, 11; visible to software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      x_prefetch_ptr_a_q <= RST_START;
      x_prefetch_ptr_b_q <= RST_START;
      y_prefetch_ptr_a_q <= RST_START;
      y_prefetch_ptr_b_q <= RST_START;
    end else begin
      if (rsp_d[0].wb_en && x_req.base_sel == 4'd8)
        x_prefetch_ptr_a_q <= rsp_d[0].wb_val;
      if (rsp_d[0].wb_en && x_req.base_sel == 4'd9)
        x_prefetch_ptr_b_q <= rsp_d[0].wb_val;
      if (rsp_d[1].wb_en && y_req.base_sel == 4'd10)
        y_prefetch_ptr_a_q <= rsp_d[1].wb_val;
      if (rsp_d[1].wb_en && y_req.base_sel == 4'd11)
        y_prefetch_ptr_b_q <= rsp_d[1].wb_val;
    end
  end

  // sticky request-error flags; write 1 clears, set wins
  logic [1:0] err_clr;
  always_ff @(posedge aclk) begin
    if (!aresetn) err_sticky_q <= 2'b00;
    else err_sticky_q <= (err_sticky_q & ~err_clr) |
                         {rsp_d[1].error, rsp_d[0].error};
  end

  // AXI4-Lite write path: address and data taken in either order
  logic wr_fire;
  assign wr_fire = wr_state_q == WR_IDLE &&
                   (aw_got_q || s_axi_awvalid) && (w_got_q || s_axi_wvalid);
  logic [31:0] wa;
  logic [31:0] wd;
  logic [3:0]  ws;
  assign wa = aw_got_q ? aw_addr_q : s_axi_awaddr;
  assign wd = w_got_q ? w_data_q : s_axi_wdata;
  assign ws = w_got_q ? w_strb_q : s_axi_wstrb;
  assign err_clr = (wr_fire && wa == OFS_STATUS && ws[0]) ? wd[1:0] : 2'b00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_q    <= WR_IDLE;
      aw_got_q      <= 1'b0;
      w_got_q       <= 1'b0;
      aw_addr_q     <= '0;
      w_data_q      <= '0;
      w_strb_q      <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      case (wr_state_q)
        WR_IDLE: begin
          if (wr_fire) begin
            s_axi_awready <= !aw_got_q;
            s_axi_wready  <= !w_got_q;
            aw_got_q      <= 1'b1;
            w_got_q       <= 1'b1;
            wr_state_q    <= WR_RESP;
            s_axi_bvalid  <= 1'b1;
            if (wa == OFS_CTRL || wa == OFS_X_START || wa == OFS_X_END ||
                wa == OFS_Y_START || wa == OFS_Y_END || wa == OFS_STATUS)
              s_axi_bresp <= RESP_OKAY;
            else
              s_axi_bresp <= RESP_SLVERR;
          end
        end
        WR_RESP: begin
          if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_got_q     <= 1'b0;
            w_got_q      <= 1'b0;
            wr_state_q   <= WR_IDLE;
          end
        end
        default: wr_state_q <= WR_IDLE;
      endcase
    end
  end

  // ready pulses the cycle after acceptance; hold payload meanwhile
  // (the master still holds valid until ready; aw_addr_q and w_data_q are never loaded)
  // note: ready is registered, so acceptance shows one cycle after fire

  // configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      circ_control_q <= RST_CTRL;
      x_circ_start_q <= RST_START;
      x_circ_end_q   <= RST_END;
      y_circ_start_q <= RST_START;
      y_circ_end_q   <= RST_END;
    end else if (wr_fire) begin
      if (wa == OFS_CTRL)
        circ_control_q <= merge16(circ_control_q, wd, ws) & CTRL_MASK;
      else if (wa == OFS_X_START) x_circ_start_q <= merge16(x_circ_start_q, wd, ws);
      else if (wa == OFS_X_END)   x_circ_end_q   <= merge16(x_circ_end_q, wd, ws);
      else if (wa == OFS_Y_START) y_circ_start_q <= merge16(y_circ_start_q, wd, ws);
      else if (wa == OFS_Y_END)   y_circ_end_q   <= merge16(y_circ_end_q, wd, ws);
    end
  end

  // AXI4-Lite read path
  logic [15:0] rd_val;
  logic        rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    if (s_axi_araddr == OFS_CTRL)         rd_val = circ_control_q;
    else if (s_axi_araddr == OFS_X_START) rd_val = x_circ_start_q;
    else if (s_axi_araddr == OFS_X_END)   rd_val = x_circ_end_q;
    else if (s_axi_araddr == OFS_Y_START) rd_val = y_circ_start_q;
    else if (s_axi_araddr == OFS_Y_END)   rd_val = y_circ_end_q;
    else if (s_axi_araddr == OFS_X_PTR_A) rd_val = x_prefetch_ptr_a_q;
    else if (s_axi_araddr == OFS_X_PTR_B) rd_val = x_prefetch_ptr_b_q;
    else if (s_axi_araddr == OFS_Y_PTR_A) rd_val = y_prefetch_ptr_a_q;
    else if (s_axi_araddr == OFS_Y_PTR_B) rd_val = y_prefetch_ptr_b_q;
    else if (s_axi_araddr == OFS_STATUS)  rd_val = {14'h0000, err_sticky_q};
    else begin
      rd_val = 16'h0000;
      rd_ok  = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid) begin
        if (s_axi_rready) s_axi_rvalid <= 1'b0;
      end else if (s_axi_arvalid && !s_axi_arready) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {16'h0000, rd_val};
        s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // assertions
  a_y_word_align: assert property (
    @(posedge aclk) disable iff (!aresetn)
    y_rsp.valid |-> y_rsp.ea[0] == 1'b0)
    else $error("y address not word aligned");
  a_offset_no_wb: assert property (
    @(posedge aclk) disable iff (!aresetn)
    x_req.valid && x_req.mode == AM_INDEXED |=> !x_rsp.wb_en)
    else $error("indexed mode wrote back pointer");
  a_post_ea_base: assert property (
    @(posedge aclk) disable iff (!aresetn)
    x_req.valid && x_req.mode == AM_POST && !c_on[0]
    |=> x_rsp.ea == $past(x_req.base_val))
    else $error("post-modify address not base");
  a_pre_ea_step: assert property (
    @(posedge aclk) disable iff (!aresetn)
    x_req.valid && x_req.mode == AM_PRE && !c_on[0]
    |=> x_rsp.ea == 16'($past(x_req.base_val) + $past(x_req.literal)))
    else $error("pre-modify address not stepped pointer");
  a_indexed_sum: assert property (
    @(posedge aclk) disable iff (!aresetn)
    x_req.valid && x_req.mode == AM_INDEXED && !c_on[0]
    |=> x_rsp.ea == 16'($past(x_req.base_val) + $past(x_req.offset_val)))
    else $error("indexed sum wrong");
  a_circ_in_range: assert property (
    @(posedge aclk) disable iff (!aresetn)
    c_on[0] && x_req.valid && !bad[0] && cand[0] <= x_circ_end_q + 16'h0040
    && cand[0] + 16'h0040 >= x_circ_start_q && x_circ_start_q < x_circ_end_q
    |-> w_ea[0] >= x_circ_start_q && w_ea[0] <= x_circ_end_q)
    else $error("circular address left buffer");
  a_x_circ_off: assert property (
    @(posedge aclk) disable iff (!aresetn)
    x_circ_pointer_select == SEL_NONE |-> w_ea[0] == cand[0])
    else $error("x circular active with select 15");
  a_y_circ_off: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !circ_control_q[CTRL_Y_EN_BIT] |-> w_ea[1] == cand[1])
    else $error("y circular active while disabled");
  a_y_mac_only: assert property (
    @(posedge aclk) disable iff (!aresetn)
    y_req.valid && y_req.iclass != IC_MAC |=> y_rsp.error)
    else $error("y unit accepted non-mac request");
endmodule // address_generator_units

// >>> verification/core_model.sv
// partner: working registers that fill requests and take writebacks
`timescale 1ns/1ns
module core_model
  import agu_pkg::*;
(
  input  wire logic    aclk,
  input  wire ea_req_t cmd_x,
  input  wire ea_req_t cmd_y,
  input  wire ea_rsp_t x_rsp,
  input  wire ea_rsp_t y_rsp,
  output ea_req_t      x_req,
  output ea_req_t      y_req
);
  logic [15:0] regs_q [16];

  // prefetch pointers start inside their own buffers
  initial for (int i = 0; i < 16; i++) begin
    regs_q[i] = (i < 10 ? 16'h1000 : 16'h2000) + 16'(i * 16);
  end

  // offset field picks a register, shared by both ends of a move
  always_comb begin
    x_req = cmd_x;
    x_req.base_val = regs_q[cmd_x.base_sel];
    x_req.offset_val = regs_q[cmd_x.offset_val[3:0]];
    y_req = cmd_y;
    y_req.base_val = regs_q[cmd_y.base_sel];
    y_req.offset_val = regs_q[cmd_y.offset_val[3:0]];
  end

  always @(posedge aclk) begin
    if (x_rsp.valid && x_rsp.wb_en) regs_q[x_rsp.wb_sel] <= x_rsp.wb_val;
    if (y_rsp.valid && y_rsp.wb_en) regs_q[y_rsp.wb_sel] <= y_rsp.wb_val;
  end
endmodule // core_model

// >>> verification/testbench.sv
// testbench: random address requests and control register accesses
`timescale 1ns/1ns
module testbench
  import agu_pkg::*;
;
  localparam logic [15:0] XS = 16'h1000, XE = 16'h10FF;
  localparam logic [15:0] YS = 16'h2000, YE = 16'h20FF;
  localparam addr_mode_t mac_m [4] = '{AM_INDIRECT, AM_POST, AM_INDEXED,
                                       AM_PRE};
  localparam logic [31:0] rst_a [6] = '{OFS_CTRL, OFS_X_START, OFS_X_END,
                                        OFS_Y_START, OFS_Y_END, OFS_STATUS};
  localparam logic [15:0] rst_v [6] = '{RST_CTRL, RST_START, RST_END,
                                        RST_START, RST_END, 16'h0000};
  localparam logic [31:0] buf_a [4] = '{OFS_X_START, OFS_X_END,
                                        OFS_Y_START, OFS_Y_END};
  localparam logic [15:0] buf_v [4] = '{XS, XE, YS, YE};
  localparam logic [15:0] phase_c [4] = '{16'h0000, 16'hC0A3, 16'hC0FF,
                                          16'h40A3};
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [31:0] awaddr = '0;
  logic [31:0] wdata = '0;
  logic [31:0] araddr = '0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, r, errs;
  logic [31:0] rdata, d;
  ea_req_t     cmd_x = '0;
  ea_req_t     cmd_y = '0;
  ea_req_t     x_req, y_req, q;
  ea_rsp_t     x_rsp, y_rsp;
  logic [15:0] mr [16];
  logic [15:0] ctrl_m = '0;
  logic [31:0] seed = 32'h0001_0EA3;
  int          miscompares = 0;
  int          comparisons = 0;

  always #50 aclk = ~aclk;

  address_generator_units dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .x_req(x_req), .y_req(y_req), .x_rsp(x_rsp),
    .y_rsp(y_rsp));
  core_model core (.aclk(aclk), .cmd_x(cmd_x), .cmd_y(cmd_y), .x_rsp(x_rsp),
    .y_rsp(y_rsp), .x_req(x_req), .y_req(y_req));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [15:0] wrap(logic [15:0] a, logic act,
                                       logic [15:0] s, logic [15:0] n);
    if (act && a > n) return a - (n - s + 16'h1);
    if (act && a < s) return a + (n - s + 16'h1);
    return a;
  endfunction

  function automatic ea_req_t fill(ea_req_t c);
    fill = c;
    fill.base_val = mr[c.base_sel];
    fill.offset_val = mr[c.offset_val[3:0]];
  endfunction

  function automatic ea_rsp_t exp_rsp(ea_req_t f, bit y);
    ea_rsp_t e;
    logic [15:0] a, w, s, n;
    logic [3:0] sel;
    logic act;
    e = '0;
    sel = y ? ctrl_m[7:4] : ctrl_m[3:0];
    act = ctrl_m[15 - y] && sel != SEL_NONE && f.base_sel == sel
          && f.mode != AM_FILE;
    s = y ? YS : XS;
    n = y ? YE : XE;
    w = f.base_val + f.literal;
    a = f.mode inside {AM_PRE, AM_LITERAL} ? w : f.base_val;
    if (f.mode == AM_INDEXED) a = f.base_val + f.offset_val;
    if (f.mode == AM_FILE) a = f.is_move ? f.literal : {3'h0, f.file_addr};
    e.valid = f.valid;
    e.error = f.valid && (y && f.iclass != IC_MAC || f.iclass == IC_MCU
      && f.mode inside {AM_INDEXED, AM_FILE} || f.iclass == IC_MAC
      && (f.base_sel[3:1] != {2'b10, y} || f.mode inside {AM_PRE,
      AM_LITERAL, AM_FILE} || f.mode == AM_INDEXED && !f.base_sel[0]
      || f.mode == AM_POST && !(f.literal inside {16'h0002, 16'h0004,
      16'h0006, 16'hFFFE, 16'hFFFC, 16'hFFFA})));
    if (e.valid && !e.error) begin
      e.ea = wrap(a, act, s, n) & (y ? WORD_MASK : 16'hFFFF);
      e.wb_en = f.mode inside {AM_POST, AM_PRE};
      e.wb_sel = f.base_sel;
      e.wb_val = wrap(w, act, s, n);
    end
    return e;
  endfunction

  function automatic ea_req_t gen(bit y);
    ea_req_t g;
    logic [31:0] v;
    v = rnd();
    g = '0;
    g.valid = 1'b1;
    g.iclass = instr_class_t'(y ? {1'b1, v[1] | v[0]} : v[1:0]);
    g.base_sel = {1'b0, v[4:2]};
    g.offset_val = {13'h0, v[14:12]};
    g.literal = {{12{v[11]}}, v[11:8]};
    g.file_addr = v[28:16];
    g.is_move = g.iclass == IC_MOVE;
    g.prog_space = !y && v[15];
    if (g.iclass == IC_FILE) g.mode = AM_FILE;
    else if (g.iclass == IC_MAC) begin
      g.base_sel = {2'b10, y, v[2]};
      g.mode = mac_m[v[6:5]];
      g.literal = {12'h0, {1'b0, v[9:8]} + 3'd1, 1'b0};
      if (v[10]) g.literal = -g.literal;
    end else g.mode = addr_mode_t'(v[7:5] % (g.is_move ? 3'd6 : 3'd5));
    if (g.mode == AM_FILE) g.base_sel = '0;
    if (g.mode == AM_FILE && g.is_move) g.literal = v[31:16];
    return g;
  endfunction

  task automatic final_report();
    if (miscompares == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e,
                         input logic [1:0] gr, input logic [1:0] er);
    comparisons++;
    if (g !== e || gr !== er) begin
      miscompares++;
      $display("unexpected at %0t: reg %h/%h want %h/%h", $time, g, gr, e, er);
    end
  endtask

  task automatic chk_rsp(input ea_rsp_t g, input ea_rsp_t e);
    comparisons++;
    if (g.valid !== e.valid || g.error !== e.error || g.wb_en !== e.wb_en
        || e.valid && !e.error && (g.ea !== e.ea || e.wb_en
        && {g.wb_sel, g.wb_val} !== {e.wb_sel, e.wb_val})) begin
      miscompares++;
      $display("unexpected at %0t: rsp %h want %h", $time, g, e);
    end
  endtask

  task automatic axi_wr(input logic [31:0] a, input logic [31:0] v,
                        output logic [1:0] rs);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [31:0] a, output logic [31:0] v,
                        output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  // one request pair, then a free cycle so writebacks land before reuse
  task automatic step(input ea_req_t cx, input ea_req_t cy);
    ea_rsp_t ex, ey;
    ex = exp_rsp(fill(cx), 1'b0);
    ey = exp_rsp(fill(cy), 1'b1);
    @(posedge aclk);
    cmd_x <= cx;
    cmd_y <= cy;
    @(posedge aclk);
    cmd_x <= '0;
    cmd_y <= '0;
    @(posedge aclk);
    chk_rsp(x_rsp, ex);
    chk_rsp(y_rsp, ey);
    errs |= {ey.error, ex.error};
    if (ex.wb_en) mr[ex.wb_sel] = ex.wb_val;
    if (ey.wb_en) mr[ey.wb_sel] = ey.wb_val;
  endtask

  initial begin
    repeat (5000) @(posedge aclk);
    miscompares++;
    final_report();
  end

  initial begin
    for (int i = 0; i < 16; i++) mr[i] = (i < 10 ? XS : YS) + 16'(i * 16);
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rst_a[i]) begin
      axi_rd(rst_a[i], d, r);
      chk_reg(d, {16'h0, rst_v[i]}, r, RESP_OKAY);
    end
    axi_rd(32'h0000_0028, d, r);
    chk_reg(d, '0, r, RESP_SLVERR);
    axi_wr(32'h0000_0040, 32'h0000_FFFF, r);
    chk_reg('0, '0, r, RESP_SLVERR);
    axi_wr(OFS_X_PTR_A, 32'h0000_1234, r);
    chk_reg('0, '0, r, RESP_SLVERR);
    axi_wr(OFS_CTRL, 32'hFFFF_FFFF, r);
    axi_rd(OFS_CTRL, d, r);
    chk_reg(d, {16'h0, CTRL_MASK}, r, RESP_OKAY);
    foreach (buf_a[i]) begin
      axi_wr(buf_a[i], {16'h0, buf_v[i]}, r);
      axi_rd(buf_a[i], d, r);
      chk_reg(d, {16'h0, buf_v[i]}, r, RESP_OKAY);
    end
    foreach (phase_c[p]) begin
      ctrl_m = phase_c[p];
      axi_wr(OFS_CTRL, {16'h0, ctrl_m}, r);
      errs = '0;
      repeat (60) step(gen(1'b0), gen(1'b1));
      axi_rd(OFS_STATUS, d, r);
      chk_reg(d, {30'h0, errs}, r, RESP_OKAY);
      axi_wr(OFS_STATUS, 32'h0000_0003, r);
      axi_rd(OFS_STATUS, d, r);
      chk_reg(d, '0, r, RESP_OKAY);
    end
    q = '0;
    q.valid = 1'b1;
    q.iclass = IC_MAC;
    q.mode = AM_POST;
    q.base_sel = 4'h8;
    q.literal = 16'h0002;
    step(q, '0);
    axi_rd(OFS_X_PTR_A, d, r);
    chk_reg(d, {16'h0, mr[8]}, r, RESP_OKAY);
    final_report();
  end
endmodule // testbench
